// [hw/dual_timer_pkg.sv]
// Shared constants for the dual timer/counter block
package dual_timer_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL_FLAGS = 8'h88;
  localparam logic [7:0] IDX_MODE_CFG = 8'h89;
  localparam logic [7:0] IDX_LOW_BYTE0 = 8'h8A;
  localparam logic [7:0] IDX_LOW_BYTE1 = 8'h8B;
  localparam logic [7:0] IDX_HIGH_BYTE0 = 8'h8C;
  localparam logic [7:0] IDX_HIGH_BYTE1 = 8'h8D;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_FLAGS_RST = 8'h00;
  localparam logic [7:0] MODE_CFG_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;

  // ----------------------------------------------------------------
  // Mode register field positions
  // ----------------------------------------------------------------
  localparam int GATE_SEL_UNIT1 = 7;
  localparam int FUNC_SEL_UNIT1 = 6;
  localparam int MODE_HI_UNIT1 = 5;
  localparam int MODE_LO_UNIT1 = 4;
  localparam int GATE_SEL_UNIT0 = 3;
  localparam int FUNC_SEL_UNIT0 = 2;
  localparam int MODE_HI_UNIT0 = 1;
  localparam int MODE_LO_UNIT0 = 0;

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int OVERFLOW_FLAG_UNIT1 = 7;
  localparam int RUN_BIT_UNIT1 = 6;
  localparam int OVERFLOW_FLAG_UNIT0 = 5;
  localparam int RUN_BIT_UNIT0 = 4;
  localparam int EXT_IRQ_FLAG_B = 3;
  localparam int EXT_IRQ_TYPE_B = 2;
  localparam int EXT_IRQ_FLAG_A = 1;
  localparam int EXT_IRQ_TYPE_A = 0;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_PRESCALE13 = 2'h0,
    MODE_CASCADE16 = 2'h1,
    MODE_RELOAD8 = 2'h2,
    MODE_SPLIT_STOP = 2'h3
  } timer_mode_t;
  localparam logic [4:0] PRESCALE_MAX = 5'h1F;
  localparam logic [7:0] BYTE_MAX = 8'hFF;

  // ----------------------------------------------------------------
  // Timing: machine cycle in oscillator periods, clk is the oscillator
  // ----------------------------------------------------------------
  localparam int MACHINE_CYCLE_OSC = 6;
  localparam int CLKS_PER_OSC = 1;
  localparam int MACHINE_CYCLE_CLKS = MACHINE_CYCLE_OSC * CLKS_PER_OSC;
  localparam int DIV_W = 3;
endpackage

// [hw/pin_sample_if.sv]
// Machine-cycle tick and sampled pin events between sampler and timer core
`timescale 1ns/1ps
`default_nettype none
interface pin_sample_if;
  logic tick;
  logic [1:0] count_fall;
  logic [1:0] irq_low;
  logic [1:0] irq_fall;
  modport src (output tick, output count_fall, output irq_low, output irq_fall);
  modport dst (input tick, input count_fall, input irq_low, input irq_fall);
endinterface
`default_nettype wire

// [hw/machine_cycle_sampler.sv]
// Machine-cycle divider and once-per-cycle sampler for count and interrupt pins
`timescale 1ns/1ps
`default_nettype none
module machine_cycle_sampler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] count_pins,
  input wire logic [1:0] irq_pins,
  pin_sample_if.src smp
);
  typedef struct packed {
    logic [dual_timer_pkg::DIV_W-1:0] div;
    logic tick;
    logic [1:0] count_prev;
    logic [1:0] irq_prev;
    logic [1:0] count_fall;
    logic [1:0] irq_low;
    logic [1:0] irq_fall;
  } sampler_state_t;

  localparam logic [dual_timer_pkg::DIV_W-1:0] DIV_LAST =
    dual_timer_pkg::DIV_W'(dual_timer_pkg::MACHINE_CYCLE_CLKS - 1);

  sampler_state_t st_ff;
  sampler_state_t nxt_st;

  // Divide by the machine cycle; sample pins once at each cycle boundary
  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    nxt_st.count_fall = 2'h0;
    nxt_st.irq_fall = 2'h0;
    if (st_ff.div == DIV_LAST) begin
      nxt_st.div = '0;
      nxt_st.tick = 1'b1;
      // High in one sample, low in the next: a falling transition
      nxt_st.count_fall = st_ff.count_prev & ~count_pins;
      nxt_st.irq_fall = st_ff.irq_prev & ~irq_pins;
      nxt_st.irq_low = ~irq_pins;
      nxt_st.count_prev = count_pins;
      nxt_st.irq_prev = irq_pins;
    end else begin
      nxt_st.div = st_ff.div + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '{div: '0, tick: 1'b0, count_prev: 2'h3, irq_prev: 2'h3,
                 count_fall: 2'h0, irq_low: 2'h0, irq_fall: 2'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign smp.tick = st_ff.tick;
  assign smp.count_fall = st_ff.count_fall;
  assign smp.irq_low = st_ff.irq_low;
  assign smp.irq_fall = st_ff.irq_fall;
endmodule
`default_nettype wire

// [hw/dual_timer_counter_block.sv]
// Two 16-bit timer/counters with mode and control registers on Avalon-MM
//
// Overview of operation
// - Timer mode counts once per six-clock machine cycle
// - Counter mode samples pin per cycle, counts falls
// - High then low sample increments next machine cycle
// - Edge needs two samples; max rate twelfth
// - Function bit picks internal cycles or count pin
// - Gate bit requires interrupt pin high plus run
// - Mode 0: low five bits prescale high byte
// - Mode 1: full sixteen-bit cascaded counter
// - Mode 2: low byte reloads from high byte
// - Unit0 mode 3: two bytes, split control
// - Unit1 mode 3 stops and holds count
// - Overflow flags set by hardware, cleared by ack/software
// - Run bits are software on/off controls
// - External flags set on edge/low, cleared by ack/software
// - Type bits software-written, select edge or level
// - Mode register resets to zero
// - Mode 0 rolls thirteen bits, sets overflow
// - Reload keeps high byte; run never clears count
// - Unit0 mode 3 high byte owns unit1 run/flag
`timescale 1ns/1ps
`default_nettype none
module dual_timer_counter_block (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [dual_timer_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [dual_timer_pkg::DATA_W-1:0] writedata,
  output logic [dual_timer_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic count_pin_unit0,
  input wire logic count_pin_unit1,
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic vector_ack_unit0,
  input wire logic vector_ack_unit1,
  input wire logic vector_ack_irq_a,
  input wire logic vector_ack_irq_b,
  output logic overflow_flag_unit0,
  output logic overflow_flag_unit1,
  output logic ext_irq_flag_a,
  output logic ext_irq_flag_b
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] timer_control_flags;
    logic [7:0] timer_mode_config;
    logic [7:0] low_byte_unit0;
    logic [7:0] high_byte_unit0;
    logic [7:0] low_byte_unit1;
    logic [7:0] high_byte_unit1;
    logic wait_ff;
    logic [dual_timer_pkg::DATA_W-1:0] rdata;
  } timer_state_t;

  // Result of one counting step: overflow plus new bytes
  typedef struct packed {
    logic ovf;
    logic [7:0] hi;
    logic [7:0] lo;
  } step_t;

  timer_state_t st_ff;
  timer_state_t nxt_st;
  pin_sample_if smp ();

  // Per-cycle pin sampler
  machine_cycle_sampler sampler (
    .clk(clk),
    .rst_n(rst_n),
    .count_pins({count_pin_unit1, count_pin_unit0}),
    .irq_pins({ext_irq_pin_b, ext_irq_pin_a}),
    .smp(smp)
  );

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // One increment of a unit in modes 0, 1 and 2
  function automatic step_t count_step(input logic [1:0] mode, input logic [7:0] hi,
                                       input logic [7:0] lo);
    step_t r;
    r.ovf = 1'b0;
    r.hi = hi;
    r.lo = lo;
    case (mode)
      dual_timer_pkg::MODE_PRESCALE13: begin
        // Upper three low-byte bits are left as they are
        if (lo[4:0] == dual_timer_pkg::PRESCALE_MAX) begin
          r.lo[4:0] = 5'h00;
          r.hi = hi + 8'h01;
          r.ovf = (hi == dual_timer_pkg::BYTE_MAX);
        end else begin
          r.lo[4:0] = lo[4:0] + 5'h01;
        end
      end
      dual_timer_pkg::MODE_CASCADE16: begin
        {r.hi, r.lo} = {hi, lo} + 16'h0001;
        r.ovf = ({hi, lo} == {dual_timer_pkg::BYTE_MAX, dual_timer_pkg::BYTE_MAX});
      end
      dual_timer_pkg::MODE_RELOAD8: begin
        if (lo == dual_timer_pkg::BYTE_MAX) begin
          r.lo = hi;
          r.ovf = 1'b1;
        end else begin
          r.lo = lo + 8'h01;
        end
      end
      default: begin
        r.lo = lo;
      end
    endcase
    return r;
  endfunction

  // Read-back of one register index, zero for unmapped
  function automatic logic [7:0] reg_read(input timer_state_t s, input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    case (idx)
      dual_timer_pkg::IDX_CTRL_FLAGS: v = s.timer_control_flags;
      dual_timer_pkg::IDX_MODE_CFG: v = s.timer_mode_config;
      dual_timer_pkg::IDX_LOW_BYTE0: v = s.low_byte_unit0;
      dual_timer_pkg::IDX_LOW_BYTE1: v = s.low_byte_unit1;
      dual_timer_pkg::IDX_HIGH_BYTE0: v = s.high_byte_unit0;
      dual_timer_pkg::IDX_HIGH_BYTE1: v = s.high_byte_unit1;
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  logic [7:0] cflags;
  logic [7:0] mcfg;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic run0;
  logic run1;
  logic en0;
  logic en1;
  logic ev0;
  logic ev1;
  logic split0;
  logic [7:0] widx;
  logic wr_go;

  // Gating, function select and event choice per unit
  always_comb begin
    cflags = st_ff.timer_control_flags;
    mcfg = st_ff.timer_mode_config;
    mode0 = {mcfg[dual_timer_pkg::MODE_HI_UNIT0], mcfg[dual_timer_pkg::MODE_LO_UNIT0]};
    mode1 = {mcfg[dual_timer_pkg::MODE_HI_UNIT1], mcfg[dual_timer_pkg::MODE_LO_UNIT1]};
    run0 = cflags[dual_timer_pkg::RUN_BIT_UNIT0];
    run1 = cflags[dual_timer_pkg::RUN_BIT_UNIT1];
    split0 = (mode0 == dual_timer_pkg::MODE_SPLIT_STOP);
    // Gate: run alone, or run with the interrupt pin sampled high
    en0 = run0 && (!mcfg[dual_timer_pkg::GATE_SEL_UNIT0] || !smp.irq_low[0]);
    // With unit 0 split, unit 1 loses its run bit and runs unless in mode 3
    en1 = (split0 || run1) &&
          (!mcfg[dual_timer_pkg::GATE_SEL_UNIT1] || !smp.irq_low[1]);
    ev0 = mcfg[dual_timer_pkg::FUNC_SEL_UNIT0] ? smp.count_fall[0] : smp.tick;
    ev1 = mcfg[dual_timer_pkg::FUNC_SEL_UNIT1] ? smp.count_fall[1] : smp.tick;
    widx = address[dual_timer_pkg::ADDR_W-1:2];
    wr_go = write && !st_ff.wait_ff && byteenable[0];
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    step_t s0;
    step_t s1;
    logic [7:0] split_lo;
    logic [7:0] split_hi;
    nxt_st = st_ff;
    s0 = count_step(mode0, st_ff.high_byte_unit0, st_ff.low_byte_unit0);
    s1 = count_step(mode1, st_ff.high_byte_unit1, st_ff.low_byte_unit1);
    split_lo = st_ff.low_byte_unit0 + 8'h01;
    split_hi = st_ff.high_byte_unit0 + 8'h01;

    // Unit 0 counting: one step per selected event, applied the next cycle
    if (split0) begin
      if (en0 && ev0) begin
        nxt_st.low_byte_unit0 = split_lo;
        if (st_ff.low_byte_unit0 == dual_timer_pkg::BYTE_MAX) begin
          nxt_st.timer_control_flags[dual_timer_pkg::OVERFLOW_FLAG_UNIT0] = 1'b1;
        end
      end
      // High byte counts machine cycles under unit 1's run bit
      if (run1 && smp.tick) begin
        nxt_st.high_byte_unit0 = split_hi;
        if (st_ff.high_byte_unit0 == dual_timer_pkg::BYTE_MAX) begin
          nxt_st.timer_control_flags[dual_timer_pkg::OVERFLOW_FLAG_UNIT1] = 1'b1;
        end
      end
    end else if (en0 && ev0) begin
      nxt_st.low_byte_unit0 = s0.lo;
      nxt_st.high_byte_unit0 = s0.hi;
      if (s0.ovf) begin
        nxt_st.timer_control_flags[dual_timer_pkg::OVERFLOW_FLAG_UNIT0] = 1'b1;
      end
    end

    // Unit 1 counting; mode 3 holds the count
    if (en1 && ev1 && mode1 != dual_timer_pkg::MODE_SPLIT_STOP) begin
      nxt_st.low_byte_unit1 = s1.lo;
      nxt_st.high_byte_unit1 = s1.hi;
      // Split unit 0 owns the unit 1 flag, so unit 1 overflow is silent
      if (s1.ovf && !split0) begin
        nxt_st.timer_control_flags[dual_timer_pkg::OVERFLOW_FLAG_UNIT1] = 1'b1;
      end
    end

    // Vector acknowledges clear flags unless the flag is newly set from clear in the same cycle
    if (vector_ack_unit0 && !(nxt_st.timer_control_flags[dual_timer_pkg::OVERFLOW_FLAG_UNIT0]
        && !cflags[dual_timer_pkg::OVERFLOW_FLAG_UNIT0])) begin
      nxt_st.timer_control_flags[dual_timer_pkg::OVERFLOW_FLAG_UNIT0] = 1'b0;
    end
    if (vector_ack_unit1 && !(nxt_st.timer_control_flags[dual_timer_pkg::OVERFLOW_FLAG_UNIT1]
        && !cflags[dual_timer_pkg::OVERFLOW_FLAG_UNIT1])) begin
      nxt_st.timer_control_flags[dual_timer_pkg::OVERFLOW_FLAG_UNIT1] = 1'b0;
    end

    // External interrupts: type one edge, type zero low level
    if (cflags[dual_timer_pkg::EXT_IRQ_TYPE_A] ? smp.irq_fall[0] : smp.irq_low[0]) begin
      nxt_st.timer_control_flags[dual_timer_pkg::EXT_IRQ_FLAG_A] = 1'b1;
    end else if (vector_ack_irq_a) begin
      nxt_st.timer_control_flags[dual_timer_pkg::EXT_IRQ_FLAG_A] = 1'b0;
    end
    if (cflags[dual_timer_pkg::EXT_IRQ_TYPE_B] ? smp.irq_fall[1] : smp.irq_low[1]) begin
      nxt_st.timer_control_flags[dual_timer_pkg::EXT_IRQ_FLAG_B] = 1'b1;
    end else if (vector_ack_irq_b) begin
      nxt_st.timer_control_flags[dual_timer_pkg::EXT_IRQ_FLAG_B] = 1'b0;
    end

    // Software write lands last so it overrides hardware updates
    if (wr_go) begin
      case (widx)
        dual_timer_pkg::IDX_CTRL_FLAGS: nxt_st.timer_control_flags = writedata[7:0];
        dual_timer_pkg::IDX_MODE_CFG: nxt_st.timer_mode_config = writedata[7:0];
        dual_timer_pkg::IDX_LOW_BYTE0: nxt_st.low_byte_unit0 = writedata[7:0];
        dual_timer_pkg::IDX_LOW_BYTE1: nxt_st.low_byte_unit1 = writedata[7:0];
        dual_timer_pkg::IDX_HIGH_BYTE0: nxt_st.high_byte_unit0 = writedata[7:0];
        dual_timer_pkg::IDX_HIGH_BYTE1: nxt_st.high_byte_unit1 = writedata[7:0];
        default: nxt_st.rdata = st_ff.rdata;
      endcase
    end

    // Bus handshake: one wait cycle, then waitrequest low for one cycle
    if ((read || write) && st_ff.wait_ff) begin
      nxt_st.wait_ff = 1'b0;
      nxt_st.rdata = {24'h000000, reg_read(st_ff, widx)};
    end else begin
      nxt_st.wait_ff = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset; a run bit set later never touches the counts
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_ff <= '{timer_control_flags: dual_timer_pkg::CTRL_FLAGS_RST,
                 timer_mode_config: dual_timer_pkg::MODE_CFG_RST,
                 low_byte_unit0: dual_timer_pkg::COUNT_RST,
                 high_byte_unit0: dual_timer_pkg::COUNT_RST,
                 low_byte_unit1: dual_timer_pkg::COUNT_RST,
                 high_byte_unit1: dual_timer_pkg::COUNT_RST,
                 wait_ff: 1'b1,
                 rdata: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign readdata = st_ff.rdata;
  assign waitrequest = st_ff.wait_ff;
  assign overflow_flag_unit0 = st_ff.timer_control_flags[dual_timer_pkg::OVERFLOW_FLAG_UNIT0];
  assign overflow_flag_unit1 = st_ff.timer_control_flags[dual_timer_pkg::OVERFLOW_FLAG_UNIT1];
  assign ext_irq_flag_a = st_ff.timer_control_flags[dual_timer_pkg::EXT_IRQ_FLAG_A];
  assign ext_irq_flag_b = st_ff.timer_control_flags[dual_timer_pkg::EXT_IRQ_FLAG_B];
endmodule
`default_nettype wire

// [verification/pin_source.sv]
// Behavioural source for the count pins and external interrupt pins
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  input wire logic clk,
  output logic [1:0] count_pins,
  output logic [1:0] irq_pins
);
  // Pins idle high, as pulled-up inputs do
  initial begin
    count_pins = 2'h3;
    irq_pins = 2'h3;
  end
  // Falling edges, each level held for two machine cycles
  task automatic falls(input int unit, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (12) @(posedge clk);
      count_pins[unit] <= 1'h0;
      repeat (12) @(posedge clk);
      count_pins[unit] <= 1'h1;
    end
    repeat (12) @(posedge clk);
  endtask
  // New interrupt pin level, held well past one machine cycle
  task automatic irq_level(input int unit, input logic lvl);
    @(posedge clk);
    irq_pins[unit] <= lvl;
    repeat (12) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// [verification/timer_block_asserts.sv]
// Concurrent checks on the ports of the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
module timer_block_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic read,
  input wire logic write,
  input wire logic [dual_timer_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest,
  input wire logic vector_ack_unit0,
  input wire logic vector_ack_unit1,
  input wire logic vector_ack_irq_a,
  input wire logic vector_ack_irq_b,
  input wire logic overflow_flag_unit0,
  input wire logic overflow_flag_unit1,
  input wire logic ext_irq_flag_a,
  input wire logic ext_irq_flag_b
);
  // ----------------------------------------------------------------
  // Bus handshake and sticky flag checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Bus answers
  req_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered after one cycle");
  wait_pulse_a: assert property ($fell(waitrequest) |=> $rose(waitrequest))
    else $error("waitrequest low for more than one cycle");
  rd_upper_a: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  rd_hold_a: assert property (waitrequest && $past(waitrequest) |-> $stable(readdata))
    else $error("read data changed outside an access");
  // Flags stay set until acknowledged or written
  ovf0_hold_a: assert property (overflow_flag_unit0 && !vector_ack_unit0 && !write |=> overflow_flag_unit0)
    else $error("overflow flag of unit 0 dropped by itself");
  ovf1_fall_a: assert property ($fell(overflow_flag_unit1) |->
      $past(vector_ack_unit1) || $past(write) || !$past(rst_n))
    else $error("overflow flag of unit 1 dropped by itself");
  irqa_hold_a: assert property (ext_irq_flag_a && !vector_ack_irq_a && !write |=> ext_irq_flag_a)
    else $error("interrupt flag a dropped by itself");
  irqb_fall_a: assert property ($fell(ext_irq_flag_b) |->
      $past(vector_ack_irq_b) || $past(write) || !$past(rst_n))
    else $error("interrupt flag b dropped by itself");
  // Main scenarios reached
  cover property (read && !waitrequest);
  cover property ($rose(overflow_flag_unit1));
  cover property ($rose(ext_irq_flag_b));
endmodule
bind dual_timer_counter_block timer_block_asserts u_chk (
  .clk(clk), .rst_n(rst_n), .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .vector_ack_unit0(vector_ack_unit0),
  .vector_ack_unit1(vector_ack_unit1), .vector_ack_irq_a(vector_ack_irq_a),
  .vector_ack_irq_b(vector_ack_irq_b), .overflow_flag_unit0(overflow_flag_unit0),
  .overflow_flag_unit1(overflow_flag_unit1), .ext_irq_flag_a(ext_irq_flag_a),
  .ext_irq_flag_b(ext_irq_flag_b)
);
`default_nettype wire

// [verification/tb.sv]
// Self-checking testbench for the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ----------------------------------------------------------------
  // Signals and register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL = dual_timer_pkg::IDX_CTRL_FLAGS;
  localparam logic [7:0] MODE = dual_timer_pkg::IDX_MODE_CFG;
  localparam logic [7:0] LO0 = dual_timer_pkg::IDX_LOW_BYTE0;
  localparam logic [7:0] LO1 = dual_timer_pkg::IDX_LOW_BYTE1;
  localparam logic [7:0] HI0 = dual_timer_pkg::IDX_HIGH_BYTE0;
  localparam logic [7:0] HI1 = dual_timer_pkg::IDX_HIGH_BYTE1;
  logic clk = 1'h0;
  logic rst_n = 1'h0;
  logic [9:0] address = 10'h000;
  logic read = 1'h0;
  logic write = 1'h0;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic [1:0] count_pins;
  logic [1:0] irq_pins;
  logic [3:0] ack = 4'h0; // Unit 0, unit 1, interrupt a, interrupt b
  logic [3:0] flags;
  int n_mismatch = 0;
  int comparisons = 0;
  // Clock of 8 ns
  always #4 clk = ~clk;
  // Design and far-side pin source
  dual_timer_counter_block DUT (
    .clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .count_pin_unit0(count_pins[0]),
    .count_pin_unit1(count_pins[1]), .ext_irq_pin_a(irq_pins[0]), .ext_irq_pin_b(irq_pins[1]),
    .vector_ack_unit0(ack[0]), .vector_ack_unit1(ack[1]), .vector_ack_irq_a(ack[2]),
    .vector_ack_irq_b(ack[3]), .overflow_flag_unit0(flags[0]),
    .overflow_flag_unit1(flags[1]), .ext_irq_flag_a(flags[2]), .ext_irq_flag_b(flags[3])
  );
  pin_source src (.clk(clk), .count_pins(count_pins), .irq_pins(irq_pins));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus access, held until waitrequest is sampled low
  task automatic bus(input logic wr_en, input logic [7:0] idx, input logic [7:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= {idx, 2'h0};
    read <= !wr_en;
    write <= wr_en;
    writedata <= {24'h0, d};
    @(posedge clk);
    while (waitrequest !== 1'h0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) n_mismatch++;
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, idx, d, q);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'h0, idx, 8'h00, q);
    check(what, q, exp);
  endtask
  // Wait for a flag under a bound, counting edges
  task automatic wait_flag(input int i, input int limit, output int n);
    n = 0;
    while (flags[i] !== 1'h1 && n < limit) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic pulse_ack(input int i);
    @(posedge clk);
    ack[i] <= 1'h1;
    @(posedge clk);
    ack[i] <= 1'h0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rd(CTRL, 32'h0, "control reset");
    rd(MODE, 32'h0, "mode reset");
    rd(HI1, 32'h0, "count reset");
    wr(8'h90, 8'h5A);
    rd(8'h90, 32'h0, "unmapped read");
    wr(MODE, 8'hA5);
    rd(MODE, 32'hA5, "mode write");
  endtask
  // Unit 1 timer auto-reload: period and high byte kept
  task automatic t_reload();
    int n;
    int m;
    wr(HI1, 8'hF0);
    wr(LO1, 8'hFE);
    wr(MODE, 8'h20);
    wr(CTRL, 8'h40);
    wait_flag(1, 40, n);
    check("reload overflow", {31'h0, flags[1]}, 32'h1);
    pulse_ack(1);
    @(posedge clk);
    check("ack clears flag", {31'h0, flags[1]}, 32'h0);
    wait_flag(1, 200, m);
    check("reload period clocks", m + 3, 32'd96);
    wr(CTRL, 8'h00);
    rd(HI1, 32'hF0, "reload keeps high");
  endtask
  // Unit 0 event counting in modes 0 and 1, then gated
  task automatic t_counter();
    wr(MODE, 8'h04);
    wr(LO0, 8'h1F);
    wr(HI0, 8'h00);
    wr(CTRL, 8'h10);
    src.falls(0, 1);
    rd(HI0, 32'h01, "prescaler carry");
    rd(LO0, 32'h00, "prescaler wrap");
    wr(MODE, 8'h05);
    wr(LO0, 8'hFF);
    wr(HI0, 8'hFF);
    src.falls(0, 1);
    check("sixteen bit overflow", {31'h0, flags[0]}, 32'h1);
    rd(HI0, 32'h00, "sixteen bit wrap");
    wr(CTRL, 8'h10);
    @(posedge clk);
    check("software clears flag", {31'h0, flags[0]}, 32'h0);
    wr(MODE, 8'h0D);
    src.irq_level(0, 1'h0);
    src.falls(0, 2);
    rd(LO0, 32'h00, "gate closed");
    src.irq_level(0, 1'h1);
    src.falls(0, 3);
    rd(LO0, 32'h03, "gate open");
    check("level flag a set", {31'h0, flags[2]}, 32'h1);
    pulse_ack(2);
    @(posedge clk);
    check("vector clears flag a", {31'h0, flags[2]}, 32'h0);
  endtask
  // Edge type on b, level type on a
  task automatic t_ext_irq();
    wr(CTRL, 8'h04);
    src.irq_level(1, 1'h0);
    check("edge flag set", {31'h0, flags[3]}, 32'h1);
    pulse_ack(3);
    @(posedge clk);
    check("edge flag acked", {31'h0, flags[3]}, 32'h0);
    src.irq_level(1, 1'h1);
    src.irq_level(0, 1'h0);
    wr(CTRL, 8'h04);
    repeat (12) @(posedge clk);
    check("level flag resets", {31'h0, flags[2]}, 32'h1);
    src.irq_level(0, 1'h1);
    wr(CTRL, 8'h04);
    @(posedge clk);
    check("level flag cleared", {31'h0, flags[2]}, 32'h0);
  endtask
  // Unit 1 as gated 16-bit event counter on its own count pin
  task automatic t_unit1();
    wr(MODE, 8'hD1);
    wr(LO1, 8'hFF);
    wr(HI1, 8'hFF);
    wr(CTRL, 8'h40);
    src.irq_level(1, 1'h0);
    src.falls(1, 1);
    rd(LO1, 32'hFF, "unit 1 gate closed");
    src.irq_level(1, 1'h1);
    src.falls(1, 1);
    check("unit 1 counter overflow", {31'h0, flags[1]}, 32'h1);
    rd(HI1, 32'h00, "unit 1 counter wrap");
    wr(CTRL, 8'h00);
  endtask
  // Unit 0 split, unit 1 stopped
  task automatic t_split();
    int n;
    wr(MODE, 8'h33);
    wr(LO1, 8'h55);
    wr(HI0, 8'hFE);
    wr(CTRL, 8'h40);
    wait_flag(1, 40, n);
    check("split high overflow", {31'h0, flags[1]}, 32'h1);
    check("split low idle", {31'h0, flags[0]}, 32'h0);
    rd(LO1, 32'h55, "unit 1 holds");
    rd(LO0, 32'h03, "split low holds");
    wr(CTRL, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic stop_test();
    $display("Mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Main sequence after a 16-cycle reset
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_reload();
    t_counter();
    t_ext_irq();
    t_unit1();
    t_split();
    stop_test();
  end
  // Watchdog well beyond the expected run of roughly seven hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    stop_test();
  end
endmodule
`default_nettype wire
